// [hw/lpc_pkg.sv]
// Behaviour
// - Cascaded main preset reloads the counter with the offset when a limit is reached.
// - In cascaded main preset, latched outputs of other limits stay off.
// - In cascaded main preset, a limit set to that mode counts relative to the offset.
// - A disabled limit never drives its output; its settings are ignored. A disabled master still sets the point of a limit trailing it.
// - First limit compares against main counter or totalizer.
// - Main counter limits are signed, -999999 up to 99999.
// - Totalizer limit: upper and lower four digits plus a sign.
// - Five modes: step, remainder reload, stop, clear previous, cascaded main preset.
// - High direction asserts at value >= limit, low at value <= limit.
// - Each output is latched or a wiper pulse.
// - Wiper pulse length is 0.0 to 9.9 s in tenths.
// - Each limit may set a display colour while value >= limit.
// - Trailing second limit follows the first by a programmed difference.
// - Positive trail: master minus value; negative: master plus value, offset ignored.
// - Fourth limit may trail the third the same way.
// - Third and fourth limits work like the first when not trailing.
// - Frequency and tachometer modes assert alarms at the limit in chosen direction.
// - Frequency outputs use a time delay or a hysteresis, per limit.
// - Delay of 0 to 99 s applies to switching on and off.
// - Hysteresis of 0 to 9999 units only moves the switch-off point.
package lpc_pkg;
  localparam int NUM_LIMITS = 4;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TENTH_NS = 100_000_000;
  localparam int TENTH_CYCLES = TENTH_NS / CLK_PERIOD_NS;
  localparam logic [9:0] SEC_TENTHS = 10'h00a;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OFFSET = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [1:0] SUB_CFG = 2'h0;
  localparam logic [1:0] SUB_LIMIT = 2'h1;
  localparam logic [1:0] SUB_QUAL = 2'h2;
  localparam int CFG_EN = 0;
  localparam int CFG_SRC_TOTAL = 1;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_DIR_LOW = 5;
  localparam int CFG_WIPER = 6;
  localparam int CFG_TRAIL = 7;
  localparam int CFG_HYST = 8;
  localparam int CFG_COLOUR_LSB = 9;
  localparam int CFG_WIPE_LSB = 16;
  localparam int CTRL_FREQ = 0;
  localparam int TOT_HI_LSB = 14;
  localparam int TOT_SIGN = 31;
  localparam logic [31:0] DIGITS4_SCALE = 32'h0000_2710;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    MODE_STEP = 3'b000,
    MODE_REMAINDER = 3'b001,
    MODE_STOP = 3'b010,
    MODE_CLEAR = 3'b011,
    MODE_CASCADE = 3'b100
  } lpc_mode_e;
endpackage

// [hw/lpc_limit_preset_comparator.sv]
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module lpc_limit_preset_comparator #(
  parameter int unsigned TENTH_CYCLES = lpc_pkg::TENTH_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic signed [31:0] mainCount,
  input wire logic signed [31:0] totalCount,
  input wire logic valueValid,
  input wire logic counterReset,
  output logic [lpc_pkg::NUM_LIMITS-1:0] limitOut,
  output logic reloadOffset,
  output logic signed [31:0] offsetValue,
  output logic countStop,
  output logic [1:0] displayColour
);
  import lpc_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] mergeStrb(logic [31:0] old, logic [31:0] nw, logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic isLimAddr(logic [7:0] a);
    return (a[7:4] >= 4'h1) && (a[7:4] <= 4'h4) && (a[3:2] != 2'h3) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [1:0] limIdx(logic [7:0] a);
    logic [3:0] d;
    d = a[7:4] - 4'h1;
    return d[1:0];
  endfunction

  // eight digits held as two four-digit halves and a sign
  function automatic logic signed [31:0] totDecode(logic [31:0] raw);
    logic [31:0] mag;
    mag = 32'(raw[TOT_HI_LSB +: 14] * DIGITS4_SCALE) + {18'h0, raw[13:0]};
    return raw[TOT_SIGN] ? -$signed(mag) : $signed(mag);
  endfunction

  // ----------------------------------------
  // register file and bus slave
  // ----------------------------------------
  logic freqMode_r;
  logic signed [31:0] offset_r;
  logic [NUM_LIMITS-1:0][31:0] cfg_r;
  logic [NUM_LIMITS-1:0][31:0] lim_r;
  logic [NUM_LIMITS-1:0][31:0] qual_r;
  logic awHeld_r, wHeld_r, bvalid_r, rvalid_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r, rdata_r;
  logic [3:0] wStrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] statusWord, readWord;
  logic doWrite, wrOk, rdOk, arTake;
  logic [1:0] wIdx, rIdx;

  assign s_axi_awready = !awHeld_r && !bvalid_r;
  assign s_axi_wready = !wHeld_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
  assign arTake = s_axi_arvalid && !rvalid_r;
  assign wIdx = limIdx(awAddr_r);
  assign rIdx = limIdx(s_axi_araddr);
  assign wrOk = (awAddr_r == ADDR_CTRL) || (awAddr_r == ADDR_OFFSET) || isLimAddr(awAddr_r);
  assign rdOk = (s_axi_araddr == ADDR_CTRL) || (s_axi_araddr == ADDR_OFFSET)
             || (s_axi_araddr == ADDR_STATUS) || isLimAddr(s_axi_araddr);
  assign readWord = !rdOk ? REG_RST
                  : (s_axi_araddr == ADDR_CTRL) ? {31'h0, freqMode_r}
                  : (s_axi_araddr == ADDR_OFFSET) ? offset_r
                  : (s_axi_araddr == ADDR_STATUS) ? statusWord
                  : (s_axi_araddr[3:2] == SUB_CFG) ? cfg_r[rIdx]
                  : (s_axi_araddr[3:2] == SUB_LIMIT) ? lim_r[rIdx]
                  : qual_r[rIdx];

  always_ff @(posedge clock) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= REG_RST;
      rresp_r <= RESP_OKAY;
    end else begin
      if (doWrite) begin
        bvalid_r <= 1'b1;
        bresp_r <= wrOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (arTake) begin
        rvalid_r <= 1'b1;
        rdata_r <= readWord;
        rresp_r <= rdOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      freqMode_r <= 1'b0;
      offset_r <= REG_RST;
      cfg_r <= '0;
      lim_r <= '0;
      qual_r <= '0;
    end else if (doWrite && wrOk) begin
      if (awAddr_r == ADDR_CTRL) begin
        freqMode_r <= wStrb_r[0] ? wData_r[CTRL_FREQ] : freqMode_r;
      end else if (awAddr_r == ADDR_OFFSET) begin
        offset_r <= mergeStrb(offset_r, wData_r, wStrb_r);
      end else if (awAddr_r[3:2] == SUB_CFG) begin
        cfg_r[wIdx] <= mergeStrb(cfg_r[wIdx], wData_r, wStrb_r);
      end else if (awAddr_r[3:2] == SUB_LIMIT) begin
        lim_r[wIdx] <= mergeStrb(lim_r[wIdx], wData_r, wStrb_r);
      end else begin
        qual_r[wIdx] <= mergeStrb(qual_r[wIdx], wData_r, wStrb_r);
      end
    end
  end

  // ----------------------------------------
  // switch points and comparison
  // ----------------------------------------
  logic [NUM_LIMITS-1:0] enVec, wiperVec, trailVec, hystVec, dirLowVec, cascVec, forceWipe;
  logic [NUM_LIMITS-1:0] hitVec, colHit, offPt, rise, clearPrev;
  logic signed [31:0] baseEff [NUM_LIMITS];
  logic signed [31:0] effLim [NUM_LIMITS];
  logic signed [31:0] cmpVal [NUM_LIMITS];
  lpc_mode_e modeOf [NUM_LIMITS];
  logic cascadeAny;

  always_comb begin
    for (int i = 0; i < NUM_LIMITS; i++) begin
      enVec[i] = cfg_r[i][CFG_EN];
      modeOf[i] = lpc_mode_e'(cfg_r[i][CFG_MODE_LSB +: 3]);
      dirLowVec[i] = cfg_r[i][CFG_DIR_LOW];
      hystVec[i] = cfg_r[i][CFG_HYST];
      wiperVec[i] = cfg_r[i][CFG_WIPER];
      cascVec[i] = enVec[i] && (modeOf[i] == MODE_CASCADE);
      trailVec[i] = (i % 2 == 1) && cfg_r[i][CFG_TRAIL];
      forceWipe[i] = (modeOf[i] == MODE_REMAINDER) || (modeOf[i] == MODE_CASCADE);
      cmpVal[i] = cfg_r[i][CFG_SRC_TOTAL] ? totalCount : mainCount;
      baseEff[i] = cfg_r[i][CFG_SRC_TOTAL] ? totDecode(lim_r[i]) : $signed(lim_r[i]);
      if (modeOf[i] == MODE_CASCADE) begin
        baseEff[i] = baseEff[i] + offset_r;
      end
    end
    for (int i = 0; i < NUM_LIMITS; i++) begin
      effLim[i] = baseEff[i];
      if (trailVec[i]) begin
        // offset left out on purpose: trailing point is tied to the master only
        effLim[i] = ($signed(lim_r[i]) > 0) ? baseEff[(i/2)*2] - $signed(lim_r[i])
                                            : baseEff[(i/2)*2] + $signed(lim_r[i]);
      end
      hitVec[i] = enVec[i] && (dirLowVec[i] ? cmpVal[i] <= effLim[i] : cmpVal[i] >= effLim[i]);
      colHit[i] = enVec[i] && (cfg_r[i][CFG_COLOUR_LSB +: 2] != 2'h0) && (cmpVal[i] >= effLim[i]);
      // hysteresis only widens the release side
      offPt[i] = dirLowVec[i] ? cmpVal[i] > effLim[i] + $signed({18'h0, qual_r[i][13:0]})
                              : cmpVal[i] < effLim[i] - $signed({18'h0, qual_r[i][13:0]});
    end
  end

  assign cascadeAny = |cascVec;

  // ----------------------------------------
  // tenth-second timebase
  // ----------------------------------------
  logic [31:0] presc_r;
  logic tick;
  assign tick = (presc_r == 32'(TENTH_CYCLES - 1));

  always_ff @(posedge clock) begin
    if (rst || tick) begin
      presc_r <= 32'h0;
    end else begin
      presc_r <= presc_r + 32'h1;
    end
  end

  // ----------------------------------------
  // output state
  // ----------------------------------------
  logic [NUM_LIMITS-1:0] hit_r, latch_r, wipe_r, qualOut_r, outNxt;
  logic [9:0] cnt_r [NUM_LIMITS];
  logic [9:0] dlyTarget [NUM_LIMITS];
  logic reload_r, stop_r;
  logic [1:0] colour_r;
  logic [1:0] colourNxt;

  always_comb begin
    colourNxt = 2'h0;
    for (int i = 0; i < NUM_LIMITS; i++) begin
      rise[i] = valueValid && hitVec[i] && !hit_r[i];
      clearPrev[i] = rise[(i+1) % NUM_LIMITS] && (modeOf[(i+1) % NUM_LIMITS] == MODE_CLEAR);
      dlyTarget[i] = 10'(qual_r[i][6:0] * SEC_TENTHS);
      outNxt[i] = enVec[i] && (freqMode_r ? qualOut_r[i]
                                          : ((latch_r[i] && !cascadeAny) || wipe_r[i]));
      if (colHit[i]) begin
        colourNxt = cfg_r[i][CFG_COLOUR_LSB +: 2];
      end
    end
  end

  for (genvar g = 0; g < NUM_LIMITS; g++) begin : g_lim
    always_ff @(posedge clock) begin
      if (rst || !enVec[g]) begin
        hit_r[g] <= 1'b0;
        latch_r[g] <= 1'b0;
        wipe_r[g] <= 1'b0;
        qualOut_r[g] <= 1'b0;
        cnt_r[g] <= 10'h0;
      end else begin
        if (valueValid) begin
          hit_r[g] <= hitVec[g];
        end
        // a new hit beats a clear arriving in the same cycle
        if (rise[g] && !wiperVec[g] && !forceWipe[g]) begin
          latch_r[g] <= 1'b1;
        end else if ((valueValid && !hitVec[g]) || clearPrev[g]) begin
          latch_r[g] <= 1'b0;
        end
        if (freqMode_r) begin
          wipe_r[g] <= 1'b0;
          if (hystVec[g]) begin
            cnt_r[g] <= 10'h0;
            if (valueValid && hitVec[g]) begin
              qualOut_r[g] <= 1'b1;
            end else if (valueValid && offPt[g]) begin
              qualOut_r[g] <= 1'b0;
            end
          end else if (hit_r[g] == qualOut_r[g]) begin
            cnt_r[g] <= 10'h0;
          end else if (dlyTarget[g] == 10'h0 || (tick && cnt_r[g] + 10'h1 >= dlyTarget[g])) begin
            qualOut_r[g] <= hit_r[g];
            cnt_r[g] <= 10'h0;
          end else if (tick) begin
            cnt_r[g] <= cnt_r[g] + 10'h1;
          end
        end else begin
          qualOut_r[g] <= 1'b0;
          // wiper of 0.0 s still lasts until the next tenth tick
          if (rise[g] && (wiperVec[g] || forceWipe[g])) begin
            wipe_r[g] <= 1'b1;
            cnt_r[g] <= {3'h0, cfg_r[g][CFG_WIPE_LSB +: 7]};
          end else if (tick && wipe_r[g]) begin
            if (cnt_r[g] == 10'h0) begin
              wipe_r[g] <= 1'b0;
            end else begin
              cnt_r[g] <= cnt_r[g] - 10'h1;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      limitOut <= '0;
      reload_r <= 1'b0;
      stop_r <= 1'b0;
      colour_r <= 2'h0;
    end else begin
      limitOut <= outNxt;
      reload_r <= !freqMode_r && |(rise & forceWipe);
      if (!freqMode_r && |(rise & {modeOf[3] == MODE_STOP, modeOf[2] == MODE_STOP,
                                   modeOf[1] == MODE_STOP, modeOf[0] == MODE_STOP})) begin
        stop_r <= 1'b1;
      end else if (counterReset) begin
        stop_r <= 1'b0;
      end
      colour_r <= colourNxt;
    end
  end

  assign reloadOffset = reload_r;
  assign offsetValue = offset_r;
  assign countStop = stop_r;
  assign displayColour = colour_r;
  assign statusWord = {20'h0, colour_r, stop_r, reload_r, hit_r, limitOut};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_reload;
    !freqMode_r && (rise[0] && cascVec[0]) |=> reloadOffset;
  endproperty
  a_reload: assert property (p_reload) else $error("cascade hit gave no reload");

  property p_cascMask;
    !freqMode_r && cascadeAny |=> (limitOut & ~$past(wipe_r)) == 4'h0;
  endproperty
  a_cascMask: assert property (p_cascMask) else $error("latched output on in cascade");

  property p_disabled;
    1'b1 |=> (limitOut & ~$past(enVec)) == 4'h0;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled limit drove output");

  property p_highDir;
    enVec[0] && !dirLowVec[0] && valueValid && cmpVal[0] >= effLim[0] |=> hit_r[0];
  endproperty
  a_highDir: assert property (p_highDir) else $error("high compare missed");

  property p_trail;
    trailVec[1] && $signed(lim_r[1]) > 0 |-> effLim[1] == baseEff[0] - $signed(lim_r[1]);
  endproperty
  a_trail: assert property (p_trail) else $error("trailing point wrong");

  property p_stop;
    !freqMode_r && rise[0] && modeOf[0] == MODE_STOP |=> countStop [*2];
  endproperty
  a_stop: assert property (p_stop) else $error("stop not held");

  property p_wiper;
    !freqMode_r && rise[0] && wiperVec[0] |=> limitOut[0] == 1'b0 ##1 limitOut[0];
  endproperty
  a_wiper: assert property (p_wiper) else $error("wiper did not start");

  property p_delayHold;
    freqMode_r && enVec[0] && !hystVec[0] && dlyTarget[0] != 10'h0 && !tick |=> $stable(qualOut_r[0]);
  endproperty
  a_delayHold: assert property (p_delayHold) else $error("delay switched early");

  property p_colour;
    colHit[3] |=> displayColour == $past(cfg_r[3][CFG_COLOUR_LSB +: 2]);
  endproperty
  a_colour: assert property (p_colour) else $error("colour not applied");

  property p_update;
    valueValid && enVec[2] |=> hit_r[2] == $past(hitVec[2]);
  endproperty
  a_update: assert property (p_update) else $error("compare not registered");

  c_reload: cover property (reloadOffset);
  c_stop: cover property (!countStop ##1 countStop);
  c_freqSwitch: cover property (freqMode_r && $rose(qualOut_r[0]));
  c_colour: cover property (displayColour != 2'h0);
endmodule // lpc_limit_preset_comparator

// [bench/lpc_count_source.sv]
`timescale 1ns/100ps
// ----------------------------------------
// counter value source and relay side
// ----------------------------------------
module lpc_count_source (
  input wire logic clock,
  input wire logic rst,
  input wire logic countEn,
  input wire logic signed [31:0] countStep,
  input wire logic counterReset,
  input wire logic reloadOffset,
  input wire logic signed [31:0] offsetValue,
  input wire logic countStop,
  output logic signed [31:0] mainCount,
  output logic signed [31:0] totalCount,
  output logic valueValid
);
  import lpc_pkg::*;
  // a reload wins over a count step, so a hit never skips the offset
  always_ff @(posedge clock) begin
    valueValid <= 1'b0;
    if (rst) begin
      mainCount <= '0;
      totalCount <= '0;
    end else if (reloadOffset || counterReset) begin
      mainCount <= offsetValue;
    end else if (countEn && !countStop) begin
      mainCount <= mainCount + countStep;
      totalCount <= totalCount + countStep;
      valueValid <= 1'b1;
    end
  end
endmodule // lpc_count_source

// [bench/limit_preset_comparator_test.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module limit_preset_comparator_test;
  import lpc_pkg::*;
  logic clock = 0, rst = 1, awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic awReady, wReady, bValid, arReady, rValid, valueValid, counterReset = 0, reloadOffset, countStop;
  logic countEn = 0;
  logic [7:0] awAddr = '0, arAddr = '0;
  logic [31:0] wData = '0, rData;
  logic [1:0] bResp, rResp, displayColour;
  logic [3:0] limitOut, ign;
  logic signed [31:0] mainCount, totalCount, offsetValue, countStep = '0;
  int error_cnt = 0, checked = 0, relCnt = 0, rel, cnt, tot, off, pt[4], md[4], col[4];
  bit en[4], lo[4], src[4], stk[4], stopM, mask, upd;
  always #4 clock = ~clock;
  always @(posedge clock) if (reloadOffset === 1'b1) relCnt++;
  lpc_limit_preset_comparator #(.TENTH_CYCLES(10)) dut_u (.clock(clock), .rst(rst),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_bresp(bResp), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_araddr(arAddr), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .mainCount(mainCount), .totalCount(totalCount), .valueValid(valueValid),
    .counterReset(counterReset), .limitOut(limitOut), .reloadOffset(reloadOffset),
    .offsetValue(offsetValue), .countStop(countStop), .displayColour(displayColour));
  lpc_count_source src_u (.clock(clock), .rst(rst), .countEn(countEn), .countStep(countStep),
    .counterReset(counterReset), .reloadOffset(reloadOffset), .offsetValue(offsetValue),
    .countStop(countStop), .mainCount(mainCount), .totalCount(totalCount), .valueValid(valueValid));
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    awAddr <= a; wData <= d; awValid <= 1'b1; wValid <= 1'b1; bReady <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge clock);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid === 1'b1) begin `CHK(bResp, er) bReady <= 1'b0; break; end
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock);
    arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge clock);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid === 1'b1) begin `CHK(rData, ed) `CHK(rResp, er) rReady <= 1'b0; break; end
    end
  endtask
  // ----------------------------------------
  // reference model
  // ----------------------------------------
  task automatic rs;
    @(posedge clock);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    cnt = 0; tot = 0; off = 0; stopM = 0; mask = 0; ign = '0; relCnt = 0; rel = 0;
    foreach (en[n]) begin en[n] = 0; stk[n] = 0; end
  endtask
  task automatic setlim(input int n, e, s, m, l, tr, c, lim);
    logic [31:0] w;
    int a;
    a = (lim < 0) ? -lim : lim;
    w = s ? (32'(a % 10000) | (32'(a / 10000) << 14) | (32'(lim < 0) << 31)) : 32'(lim);
    wr(8'h10 + 8'(16 * n), 32'(e | (s << 1) | (m << 2) | (l << 5) | (tr << 7) | (c << 9)), RESP_OKAY);
    wr(8'h14 + 8'(16 * n), w, RESP_OKAY);
    en[n] = e; src[n] = s; md[n] = m; lo[n] = l; col[n] = c; pt[n] = lim;
  endtask
  task automatic chk;
    logic [3:0] e;
    logic [1:0] c;
    int v, p;
    bit hit;
    e = '0; c = '0; hit = 0;
    for (int n = 0; n < 4; n++) begin
      v = src[n] ? tot : cnt;
      p = pt[n] + ((md[n] == MODE_CASCADE) ? off : 0);
      // latched output tracks the compare, but only on a value update
      if (upd) stk[n] = en[n] && (lo[n] ? v <= p : v >= p);
      if (upd && stk[n]) begin
        if (md[n] == MODE_STOP) stopM = 1;
        if (md[n] == MODE_CASCADE) hit = 1;
      end
      e[n] = stk[n] && !mask;
      if (en[n] && col[n] != 0 && v >= p) c = 2'(col[n]);
    end
    if (hit) begin cnt = off; rel++; end
    `CHK(limitOut & ~ign, e)
    `CHK(displayColour, c)
    `CHK(countStop, stopM)
    `CHK(mainCount, cnt)
    `CHK(relCnt, rel)
  endtask
  task automatic stepc(input int s, input int k);
    repeat (k) begin
      @(posedge clock);
      countEn <= 1'b1; countStep <= s;
      @(posedge clock);
      countEn <= 1'b0;
      repeat (4) @(posedge clock);
      if (!stopM) begin cnt += s; tot += s; end
      upd = 1;
      chk;
    end
  endtask
  task automatic clr;
    @(posedge clock);
    counterReset <= 1'b1;
    @(posedge clock);
    counterReset <= 1'b0;
    repeat (3) @(posedge clock);
    cnt = off; stopM = 0; upd = 0;
    chk;
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    #400000;
    error_cnt++;
    print_verdict;
  end
  initial begin
    logic [31:0] r;
    int lim;
    void'($urandom(32'h3c79b507));
    rs;
    rd(ADDR_CTRL, REG_RST, RESP_OKAY);
    rd(ADDR_STATUS, REG_RST, RESP_OKAY);
    rd(8'h0c, 32'h0, RESP_SLVERR);
    wr(8'h0c, 32'h5a5a_0001, RESP_SLVERR);
    r = $urandom;
    wr(ADDR_OFFSET, r, RESP_OKAY);
    rd(ADDR_OFFSET, r, RESP_OKAY);
    // latched step limits, totalizer source, disabled limit, low direction
    rs;
    lim = $urandom_range(3, 7);
    setlim(0, 1, 1, MODE_STEP, 0, 0, 1, lim);
    setlim(1, 0, 0, MODE_STEP, 0, 0, 3, 0);
    setlim(2, 1, 0, MODE_STEP, 0, 0, 2, lim + 2);
    setlim(3, 1, 0, MODE_STEP, 1, 0, 0, -2);
    stepc(1, 10);
    stepc(-1, 12);
    // stop mode holds the count until a reset
    rs;
    setlim(0, 1, 0, MODE_STOP, 0, 0, 0, 3);
    stepc(1, 5);
    clr;
    stepc(1, 1);
    // cascade reload to the offset masks other latched outputs
    rs;
    wr(ADDR_OFFSET, 32'h0000_000a, RESP_OKAY);
    off = 10;
    clr;
    `CHK(offsetValue, 32'h0000_000a)
    setlim(0, 1, 0, MODE_CASCADE, 0, 0, 0, 3);
    setlim(1, 1, 0, MODE_STEP, 0, 0, 0, 0);
    mask = 1; ign = 4'h1;
    stepc(1, 7);
    // trailing point lies before the master for both signs
    foreach (pt[i]) if (i < 2) begin
      rs;
      setlim(0, 1, 0, MODE_STEP, 0, 0, 1, 10);
      setlim(1, 1, 0, MODE_STEP, 0, 1, 2, i ? -3 : 3);
      pt[1] = 7;
      stepc(1, 12);
    end
    // frequency mode, hysteresis of 2 below a high limit of 5
    rs;
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    wr(8'h10, 32'h0000_0101, RESP_OKAY);
    wr(8'h14, 32'h0000_0005, RESP_OKAY);
    wr(8'h18, 32'h0000_0002, RESP_OKAY);
    ign = 4'h1;
    stepc(1, 5);
    `CHK(limitOut[0], 1'b1)
    stepc(-1, 2);
    `CHK(limitOut[0], 1'b1)
    stepc(-1, 1);
    `CHK(limitOut[0], 1'b0)
    print_verdict;
  end
endmodule // limit_preset_comparator_test
